// ===== core/ibs_pkg.sv
// package for the interrupt and block sync block: register map, fields, timing.
// assumes a 32-bit apb slave; one clock pclk at 100 mhz stands in for the master clock.
package ibs_pkg;
   localparam int unsigned NUM_EVENTS = 8;
   localparam logic [11:0] OFF_MASK = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_CTRL = 12'h008;
   localparam logic [11:0] OFF_BLOCK = 12'h00C;
   localparam int unsigned CTRL_POL_BIT = 0;
   localparam int unsigned CTRL_OD_BIT = 1;
   localparam int unsigned CTRL_BBDIR_BIT = 2;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] SUBFRAMES_PER_BLOCK = 8'hBF;
   localparam int unsigned SYNC_MIN_CLKS = 3;
   localparam logic [1:0] SYNC_CNT_MAX = 2'h3;

   typedef struct packed {
      logic out;
      logic oe;
   } ibs_pin_s;
endpackage

// ===== core/ibs_top.sv
// interrupt request pin and block boundary pin with an apb register file.
// assumes event pulses and the subframe strobe are synchronous to pclk.
// Notes on behaviour
// - request asserted only for unmasked events
// - status registers record causes, readable
// - control selects polarity and open-drain style
// - request holds until status read clears or a mask write removes its bit
// - output mode drives high in first subframe
// - input high three clocks forces block start
`timescale 1ns/1ps
module ibs_top
   import ibs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // events and framing
   input wire logic [NUM_EVENTS-1:0] event_in,
   input wire logic subframe_strobe,
   output logic block_start,
   // pins
   output ibs_pin_s irq_pin,
   input wire logic block_boundary_sync_in,
   output ibs_pin_s block_boundary_sync
);
   logic [7:0] mask_ff, nxt_mask;
   logic [7:0] status_ff, nxt_status;
   logic [2:0] ctrl_ff, nxt_ctrl;
   logic [7:0] sf_cnt_ff, nxt_sf_cnt;
   logic [1:0] hi_cnt_ff, nxt_hi_cnt;
   logic force_ff, nxt_force;
   logic [31:0] rdata_ff, nxt_rdata;
   logic err_ff, nxt_err;
   // rdata_ff also names the status bits handed out, so only those get cleared
   logic apb_setup, access, wr, rd, irq_act, bb_input, sync_hit;

   assign apb_setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   assign pready = 1'b1;
   assign prdata = rdata_ff;
   assign pslverr = err_ff;
   assign bb_input = ctrl_ff[CTRL_BBDIR_BIT];

   // read data and error are latched in the setup cycle, so they stand in the access
   // cycle while pready is high; flip-flop outputs at zero wait states
   always_comb begin
      nxt_mask = mask_ff;
      nxt_ctrl = ctrl_ff;
      nxt_status = status_ff;
      nxt_rdata = rdata_ff;
      nxt_err = 1'b0;
      if (apb_setup) begin
         unique case (paddr)
            OFF_MASK: nxt_rdata = {24'h00_0000, mask_ff};
            OFF_STATUS: nxt_rdata = {24'h00_0000, status_ff};
            OFF_CTRL: nxt_rdata = {29'h0000_0000, ctrl_ff};
            OFF_BLOCK: nxt_rdata = {24'h00_0000, sf_cnt_ff};
            default: begin
               // unmapped: error pulse, no effect
               nxt_rdata = 32'h0000_0000;
               nxt_err = 1'b1;
            end
         endcase
      end
      // only the bits handed to the host are cleared: an event after the setup cycle
      // stays pending, and one in the access cycle sets again (set wins)
      if (rd && paddr == OFF_STATUS) begin
         nxt_status = status_ff & ~rdata_ff[7:0];
      end
      nxt_status = nxt_status | event_in;
      if (wr) begin
         unique case (paddr)
            OFF_MASK: nxt_mask = pwdata[7:0];
            OFF_CTRL: nxt_ctrl = pwdata[2:0];
            // status and block registers are read only
            default: ;
         endcase
      end
   end

   // request follows masked sticky status, so it drops once the read cleared it or a mask write cleared its bit
   assign irq_act = |(status_ff & mask_ff);

   // pol bit 1 means active high; open drain drives only the active level and floats
   // otherwise, so the board pull must sit at the idle level
   always_comb begin
      if (ctrl_ff[CTRL_OD_BIT]) begin
         irq_pin.out = ctrl_ff[CTRL_POL_BIT];
         irq_pin.oe = irq_act;
      end else begin
         irq_pin.out = irq_act ~^ ctrl_ff[CTRL_POL_BIT];
         irq_pin.oe = 1'b1;
      end
   end

   // the boundary input is only counted while the pin is configured as an input
   always_comb begin
      nxt_hi_cnt = hi_cnt_ff;
      nxt_force = force_ff;
      nxt_sf_cnt = sf_cnt_ff;
      if (bb_input && block_boundary_sync_in) begin
         if (hi_cnt_ff != SYNC_CNT_MAX) begin
            nxt_hi_cnt = hi_cnt_ff + 2'h1;
         end
      end else begin
         nxt_hi_cnt = 2'h0;
      end
      // the third consecutive high clock arms the force; the counter saturates, so a
      // long high level arms it once only
      sync_hit = nxt_hi_cnt == SYNC_CNT_MAX && hi_cnt_ff != SYNC_CNT_MAX;
      if (subframe_strobe) begin
         // an odd index ends a frame, so a forced start lands on the next frame
         if (force_ff && sf_cnt_ff[0]) begin
            nxt_sf_cnt = 8'h00;
            nxt_force = 1'b0;
         end else if (sf_cnt_ff == SUBFRAMES_PER_BLOCK) begin
            nxt_sf_cnt = 8'h00;
         end else begin
            nxt_sf_cnt = sf_cnt_ff + 8'h01;
         end
      end
      // a new arming in the cycle that spends the old one wins
      if (sync_hit) begin
         nxt_force = 1'b1;
      end
   end

   // the counter holds the subframe index and wraps after the package's last index;
   // even indices open a frame, index zero opens a block
   assign block_start = subframe_strobe && nxt_sf_cnt == 8'h00;

   always_comb begin
      block_boundary_sync.oe = ~bb_input;
      block_boundary_sync.out = ~bb_input && sf_cnt_ff == 8'h00;
   end

   // the reset branch loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= MASK_RST;
         ctrl_ff <= CTRL_RST;
         status_ff <= 8'h00;
         sf_cnt_ff <= 8'h00;
         hi_cnt_ff <= 2'h0;
         force_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         ctrl_ff <= nxt_ctrl;
         status_ff <= nxt_status;
         sf_cnt_ff <= nxt_sf_cnt;
         hi_cnt_ff <= nxt_hi_cnt;
         force_ff <= nxt_force;
         rdata_ff <= nxt_rdata;
         err_ff <= nxt_err;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_irq_masked: assert property (!(|(status_ff & mask_ff)) |->
      (ctrl_ff[CTRL_OD_BIT] ? !irq_pin.oe : irq_pin.out == !ctrl_ff[CTRL_POL_BIT]))
      else $error("request active with no unmasked status");
   a_irq_active: assert property (|(status_ff & mask_ff) |->
      (ctrl_ff[CTRL_OD_BIT] ? irq_pin.oe : irq_pin.out == ctrl_ff[CTRL_POL_BIT]))
      else $error("request not active with unmasked status");
   a_mask_write: assert property (wr && paddr == OFF_MASK |=>
      mask_ff == $past(pwdata[7:0])) else $error("mask write lost");
   a_status_sets: assert property (|event_in |=>
      (status_ff & $past(event_in)) == $past(event_in)) else $error("event not recorded");
   a_status_sticky: assert property (|status_ff && !(rd && paddr == OFF_STATUS) |=>
      (status_ff & $past(status_ff)) == $past(status_ff))
      else $error("status lost without read");
   a_read_clears: assert property (rd && paddr == OFF_STATUS |=>
      (status_ff & $past(rdata_ff[7:0] & ~event_in)) == 8'h00)
      else $error("read did not clear status");
   a_status_capture: assert property (apb_setup && paddr == OFF_STATUS |=>
      prdata == {24'h00_0000, $past(status_ff)}) else $error("status read data wrong");
   a_err_access: assert property (pslverr |-> access)
      else $error("slave error outside access cycle");
   a_ctrl_write: assert property (wr && paddr == OFF_CTRL |=>
      ctrl_ff == $past(pwdata[2:0])) else $error("control write lost");
   a_od_float: assert property (ctrl_ff[CTRL_OD_BIT] && irq_pin.oe |->
      irq_pin.out == ctrl_ff[CTRL_POL_BIT]) else $error("open drain drives idle level");
   a_push_pull: assert property (!ctrl_ff[CTRL_OD_BIT] |-> irq_pin.oe)
      else $error("push-pull request not driven");
   a_bb_out_low: assert property (!bb_input && sf_cnt_ff != 8'h00 |->
      !block_boundary_sync.out) else $error("boundary high outside first subframe");
   a_bb_out_high: assert property (!bb_input && sf_cnt_ff == 8'h00 |->
      block_boundary_sync.oe && block_boundary_sync.out)
      else $error("boundary low in first subframe");
   a_block_wrap: assert property (subframe_strobe && sf_cnt_ff == SUBFRAMES_PER_BLOCK
      |-> block_start) else $error("block did not wrap");
   a_bb_in_float: assert property (bb_input |-> !block_boundary_sync.oe)
      else $error("boundary driven in input mode");
   a_force_three: assert property (!(bb_input && block_boundary_sync_in) ##1
      (bb_input && block_boundary_sync_in) [*3] |=> force_ff)
      else $error("three-clock high did not force start");
   a_forced_frame: assert property (force_ff && subframe_strobe && sf_cnt_ff[0] |->
      block_start) else $error("forced start missed frame boundary");
   a_no_force_short: assert property (!force_ff && !block_boundary_sync_in |=>
      !force_ff) else $error("force without input high");
   c_irq_raise: cover property (!irq_act ##1 irq_act);
   c_irq_clear: cover property (irq_act ##1 !irq_act);
   c_forced: cover property (force_ff ##[1:400] block_start);
   c_block: cover property (block_start);
   c_od_drive: cover property (ctrl_ff[CTRL_OD_BIT] && irq_pin.oe);
endmodule

// ===== tb/ibs_sync_model.sv
// far-side framing logic on the block boundary wire.
// assumes a pull-down on the wire, so released it reads low.
`timescale 1ns/1ps
module ibs_sync_model
   import ibs_pkg::*;
(
   // clock and request
   input wire logic pclk,
   input wire logic force_req,
   // wire
   input wire ibs_pin_s pin,
   output logic wire_lvl
);
   logic [1:0] cnt_ff = 2'h0;
   // holds exactly the minimum, so a device that needs more misses it
   always_ff @(posedge pclk)
      cnt_ff <= force_req ? SYNC_CNT_MAX : cnt_ff - {1'h0, cnt_ff != 2'h0};
   assign wire_lvl = pin.oe ? pin.out : cnt_ff != 2'h0;
endmodule

// ===== tb/ibs_top_test.sv
// bench for ibs_top: apb master, events, subframe strobes.
// assumes read data and slave error stand in the access cycle; taken at its edge.
`timescale 1ns/1ps
module ibs_top_test;
   import ibs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sf = 0, frc = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [7:0] ev = 8'h00;
   logic pready, pslverr, bst, bbw, err;
   ibs_pin_s irq, bb;
   int error_cnt = 0, checked = 0;
   always #5 pclk = ~pclk;
   ibs_top i_ibs_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_in(ev), .subframe_strobe(sf), .block_start(bst),
      .irq_pin(irq), .block_boundary_sync_in(bbw), .block_boundary_sync(bb));
   ibs_sync_model i_ibs_sync_model(.pclk(pclk), .force_req(frc), .pin(bb), .wire_lvl(bbw));
   task automatic wrap_up;
      $display("mismatches %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) begin
         error_cnt++;
         wrap_up();
      end else begin
         // the answer is taken at the edge that completes the access
         rd = prdata;
         err = pslverr;
         psel <= 0;
         penable <= 0;
         #1;
      end
   endtask
   task automatic pulse;
      @(posedge pclk);
      ev <= 8'h08;
      @(posedge pclk);
      ev <= 8'h00;
      @(posedge pclk);
      #1;
   endtask
   task automatic strobe(output logic s);
      @(posedge pclk);
      sf <= 1;
      #1 s = bst;
      @(posedge pclk);
      sf <= 0;
      #1;
   endtask
   task automatic t_irq;
      pulse();
      chk("irq masked", 1, irq.out);
      apb(1, OFF_MASK, 32'h0000_0008);
      apb(0, OFF_STATUS, 0);
      pulse();
      chk("irq held", 0, irq.out);
      apb(0, OFF_STATUS, 0);
      chk("status", 32'h0000_0008, rd);
      chk("no error", 0, err);
      chk("irq released", 1, irq.out);
      apb(0, OFF_STATUS, 0);
      chk("status cleared", 0, rd);
      apb(0, 12'h010, 0);
      chk("unmapped", 1, err);
   endtask
   task automatic t_pol;
      apb(1, OFF_CTRL, 32'h0000_0001);
      pulse();
      chk("active high", 1, irq.out);
      apb(0, OFF_STATUS, 0);
      chk("idle high pol", 0, irq.out);
      apb(1, OFF_CTRL, 32'h0000_0002);
      chk("od idle", 0, irq.oe);
      pulse();
      chk("od active", 1, irq);
      apb(1, OFF_CTRL, 32'h0000_0003);
      chk("od active high", 3, irq);
      apb(0, OFF_STATUS, 0);
      chk("od idle high", 2, irq);
   endtask
   task automatic t_blk;
      logic s;
      for (int k = 0; k <= SUBFRAMES_PER_BLOCK; k++) begin
         strobe(s);
         chk("boundary", k == SUBFRAMES_PER_BLOCK, bb.out);
         chk("block start", k == SUBFRAMES_PER_BLOCK, s);
      end
      apb(1, OFF_CTRL, 32'h0000_0004);
      chk("pin released", 0, bb.oe);
      strobe(s);
      @(posedge pclk);
      frc <= 1;
      @(posedge pclk);
      frc <= 0;
      repeat (4) @(posedge pclk);
      strobe(s);
      chk("forced start", 1, s);
      strobe(s);
      chk("single start", 0, s);
      apb(0, OFF_BLOCK, 0);
      chk("block index", 1, rd);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      #1;
      chk("irq idle", 3, irq);
      chk("boundary first", 1, bb.out);
      t_irq();
      t_pol();
      t_blk();
      wrap_up();
   end
endmodule
